/* hw/mpks_pkg.sv */
// Purpose: constants shared by the power key sequencer
// Assumes: 50 MHz clock
// Notes: long counts are overridable parameters of the top module
package mpks_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int KEY_MIN_MS = 1000; // least power key low time
	localparam int RBT_MIN_MS = 200; // least reboot low time
	localparam int KEY_CYCLES = (CLK_HZ / 1000) * KEY_MIN_MS;
	localparam int RBT_CYCLES = (CLK_HZ / 1000) * RBT_MIN_MS;
	localparam int DETACH_CYCLES = 16; // detach handshake timeout
	localparam int CNT_W = 27;
	localparam logic [1:0] RST_SYNC = 2'h3; // pin synchronisers reset high
	typedef enum logic [2:0] {
		ST_OFF, ST_BOOT, ST_ON, ST_DETACH, ST_SHUT
	} mpks_state_t;
endpackage : mpks_pkg

/* hw/mpks_lowtimer.sv */
// Purpose: synchronise an active-low pin and report a qualified low pulse on release
// Assumes: pin idles high through an internal pull-up
// Notes: pulse shorter than MIN_CYCLES is ignored
`timescale 1ns/1ps
module mpks_lowtimer #(
	parameter int MIN_CYCLES = 1000
) (
	input wire logic clk, // clock
	input wire logic rst_n, // async reset
	input wire logic ce, // clock enable
	input wire logic pin_n, // raw pin
	output logic released // one-cycle pulse after a long enough low
);
	logic [1:0] sync;
	logic [26:0] cnt;
	logic armed;
	logic [1:0] next_sync;
	logic [26:0] next_cnt;
	logic next_armed;
	logic next_released;

	// count low time; sync[1] only is read, sync[0] feeds it alone
	always_comb begin
		next_sync = {sync[0], pin_n};
		next_cnt = cnt;
		next_armed = armed;
		next_released = 1'b0;
		if (!sync[1]) begin
			if (cnt >= 27'(MIN_CYCLES - 1))
				next_armed = 1'b1;
			else
				next_cnt = cnt + 27'h000_0001;
		end else begin
			next_released = armed; // act only at release
			next_armed = 1'b0;
			next_cnt = 27'h000_0000;
		end
	end

	// registers hold while clock enable is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync <= mpks_pkg::RST_SYNC;
			cnt <= 27'h000_0000;
			armed <= 1'b0;
			released <= 1'b0;
		end else if (ce) begin
			sync <= next_sync;
			cnt <= next_cnt;
			armed <= next_armed;
			released <= next_released;
		end
	end
endmodule : mpks_lowtimer

/* hw/mpks_top.sv */
// Purpose: power-on, power-off and reboot sequencing from key and reboot pins
// Assumes: host drives pins open-collector; internal pull-ups hold them high
// Notes:
// Function
// RL1: host holds power key low at least one second to switch on
// RL2: same pulse switches off; shutdown starts only after key release
// RL3: every shutdown first sends a network detach request
// RL4: power good output goes low once fully powered off; here it drops on entering ST_SHUT, one cycle before O_POWER_EN
// RL5: host holds reboot line low at least 200 ms to reboot
// RL6: charger supply with battery present also powers module fully on
// RL7: power key driven open-collector only, no external pull-up; sim host mpks_host drives it push-pull
// RL8: reboot line driven open-collector only, no pull-up or push-pull; sim host mpks_host drives it push-pull
// RL9: host should always control reboot line for emergency recovery
// RL10: host waits for power good low before a new power-on pulse
`timescale 1ns/1ps
module mpks_top #(
	parameter int KEY_CYCLES = mpks_pkg::KEY_CYCLES, // power key qualify time
	parameter int RBT_CYCLES = mpks_pkg::RBT_CYCLES // reboot qualify time
) (
	input wire logic I_MCLK, // 50 MHz clock
	input wire logic I_RST_N, // async reset, active low
	input wire logic I_CE, // clock enable
	input wire logic I_PWR_KEY_N, // power key pin, active low
	input wire logic I_REBOOT_N, // reboot pin, active low
	input wire logic I_CHARGER_PRESENT, // charger supply present, async
	input wire logic I_BATTERY_PRESENT, // battery_supply pads populated, async
	input wire logic I_SW_SHUTDOWN, // software shutdown request, pulse
	input wire logic I_DETACH_DONE, // network detach acknowledged, pulse
	output logic O_POWER_GOOD_OUT, // power_good_out, high while on
	output logic O_DETACH_REQ, // detach request to network stack
	output logic O_CORE_RESET_N, // reset to radio core, active low
	output logic O_POWER_EN // supply enable for module domains
);
	logic key_rel;
	logic rbt_rel;
	logic [1:0] chg_sync;
	logic [1:0] bat_sync;
	mpks_pkg::mpks_state_t state, next_state;
	logic [4:0] tmo, next_tmo;
	logic next_pg, next_det, next_crst, next_pen;
	logic chg_ok;

	// power key pin qualifier
	mpks_lowtimer #(.MIN_CYCLES(KEY_CYCLES)) u_key (
		.clk(I_MCLK),
		.rst_n(I_RST_N),
		.ce(I_CE),
		.pin_n(I_PWR_KEY_N),
		.released(key_rel)
	);

	// reboot pin qualifier
	mpks_lowtimer #(.MIN_CYCLES(RBT_CYCLES)) u_rbt (
		.clk(I_MCLK),
		.rst_n(I_RST_N),
		.ce(I_CE),
		.pin_n(I_REBOOT_N),
		.released(rbt_rel)
	);

	// two-flop sync of supply sense levels
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			chg_sync <= 2'h0;
			bat_sync <= 2'h0;
		end else if (I_CE) begin
			chg_sync <= {chg_sync[0], I_CHARGER_PRESENT};
			bat_sync <= {bat_sync[0], I_BATTERY_PRESENT};
		end
	end

	assign chg_ok = chg_sync[1] && bat_sync[1]; // RL6

	// sequencer; in ST_ON and ST_DETACH reboot outranks every other event
	always_comb begin
		next_state = state;
		next_tmo = tmo;
		unique case (state)
			mpks_pkg::ST_OFF: begin
				if (key_rel || chg_ok) // RL1 RL6
					next_state = mpks_pkg::ST_BOOT;
			end
			mpks_pkg::ST_BOOT: begin
				next_state = mpks_pkg::ST_ON; // one cycle of held core reset
			end
			mpks_pkg::ST_ON: begin
				if (rbt_rel)
					next_state = mpks_pkg::ST_BOOT; // RL5
				else if (key_rel || I_SW_SHUTDOWN) begin
					next_state = mpks_pkg::ST_DETACH; // RL2 RL3
					next_tmo = 5'h00;
				end
			end
			mpks_pkg::ST_DETACH: begin
				// timeout so a dead network stack cannot block power-off
				if (rbt_rel)
					next_state = mpks_pkg::ST_BOOT;
				else if (I_DETACH_DONE || tmo == 5'(mpks_pkg::DETACH_CYCLES - 1))
					next_state = mpks_pkg::ST_SHUT; // RL3
				else
					next_tmo = tmo + 5'h01;
			end
			mpks_pkg::ST_SHUT: begin
				next_state = mpks_pkg::ST_OFF;
			end
			default: next_state = mpks_pkg::ST_OFF;
		endcase
		next_pg = (next_state == mpks_pkg::ST_ON) || (next_state == mpks_pkg::ST_DETACH); // RL4
		next_det = (next_state == mpks_pkg::ST_DETACH); // RL3
		next_crst = (next_state == mpks_pkg::ST_ON) || (next_state == mpks_pkg::ST_DETACH);
		next_pen = (next_state != mpks_pkg::ST_OFF);
	end

	// state and outputs registered together
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state <= mpks_pkg::ST_OFF;
			tmo <= 5'h00;
			O_POWER_GOOD_OUT <= 1'b0;
			O_DETACH_REQ <= 1'b0;
			O_CORE_RESET_N <= 1'b0;
			O_POWER_EN <= 1'b0;
		end else if (I_CE) begin
			state <= next_state;
			tmo <= next_tmo;
			O_POWER_GOOD_OUT <= next_pg;
			O_DETACH_REQ <= next_det;
			O_CORE_RESET_N <= next_crst;
			O_POWER_EN <= next_pen;
		end
	end
endmodule : mpks_top

/* sim/mpks_monitor.sv */
// Purpose: port checker for mpks_top
// Assumes: clock enable held high
// Notes: bound from tb
`timescale 1ns/1ps
module mpks_monitor (
	input wire logic I_MCLK, // clk
	input wire logic I_RST_N, // rst
	input wire logic I_DETACH_DONE, // ack
	input wire logic O_POWER_GOOD_OUT, // on
	input wire logic O_DETACH_REQ, // det
	input wire logic O_CORE_RESET_N, // core
	input wire logic O_POWER_EN // supply
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	// supply, detach and boot order checks; off_det_a: every shutdown must pass the detach phase
	pg_en_a: assert property (O_POWER_GOOD_OUT |-> O_POWER_EN) else $error("pg sup");
	core_en_a: assert property (O_CORE_RESET_N |-> O_POWER_EN) else $error("core");
	det_on_a: assert property (O_DETACH_REQ |-> O_POWER_GOOD_OUT) else $error("det");
	det_rise_a: assert property ($rose(O_DETACH_REQ) |-> $past(O_POWER_GOOD_OUT))
		else $error("rise");
	det_end_a: assert property ($rose(O_DETACH_REQ) |-> ##[1:18] !O_DETACH_REQ)
		else $error("len");
	ack_end_a: assert property (O_DETACH_REQ && I_DETACH_DONE |=> !O_DETACH_REQ)
		else $error("ack");
	off_det_a: assert property ($fell(O_POWER_EN) |-> $past(O_DETACH_REQ, 2))
		else $error("off");
	boot_on_a: assert property ($rose(O_POWER_GOOD_OUT) |-> !$past(O_CORE_RESET_N)
		&& $past(O_POWER_EN)) else $error("boot");
endmodule : mpks_monitor

/* sim/mpks_host.sv */
// Purpose: host pulling key and reboot pins low
// Assumes: internal pull-ups
// Notes: a released pin reads high
`timescale 1ns/1ps
module mpks_host (
	input wire logic i_clk, // clock
	output wire logic o_key_n, // key pin
	output wire logic o_rbt_n // reboot pin
);
	logic key_dn = 0;
	logic rbt_dn = 0;
	// push-pull: drive low while held, drive high once let go
	assign o_key_n = !key_dn;
	assign o_rbt_n = !rbt_dn;
	// hold a pin low for n edges, then let go
	task automatic press(input bit r, input int n);
		@(posedge i_clk);
		#1;
		if (r) rbt_dn = 1; else key_dn = 1;
		repeat (n) @(posedge i_clk);
		#1;
		{key_dn, rbt_dn} = 2'h0;
	endtask : press
endmodule : mpks_host

/* sim/tb.sv */
// Purpose: bench for mpks_top
// Assumes: counts cut to 20 and 8
// Notes: state seen as {good, detach, supply}
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module tb;
	logic I_MCLK = 0, I_RST_N = 0, I_CE = 1, I_CHARGER_PRESENT = 0, I_BATTERY_PRESENT = 0;
	logic I_SW_SHUTDOWN = 0, I_DETACH_DONE = 0;
	logic O_POWER_GOOD_OUT, O_DETACH_REQ, O_CORE_RESET_N, O_POWER_EN;
	wire I_PWR_KEY_N, I_REBOOT_N;
	int fail_count = 0, num_checks = 0;
	mpks_top #(.KEY_CYCLES(20), .RBT_CYCLES(8)) i_mpks_top (.*);
	mpks_host i_mpks_host (.i_clk(I_MCLK), .o_key_n(I_PWR_KEY_N), .o_rbt_n(I_REBOOT_N));
	initial forever #10 I_MCLK = ~I_MCLK;
	task automatic cyc(input int n);
		repeat (n) @(posedge I_MCLK);
		#1;
	endtask : cyc
	// bounded wait so a stuck state shows as a mismatch
	task automatic w(input logic [2:0] v);
		for (int i = 0; i < 40 && {O_POWER_GOOD_OUT, O_DETACH_REQ, O_POWER_EN} !== v; i++) cyc(1);
		`CHK({O_POWER_GOOD_OUT, O_DETACH_REQ, O_POWER_EN}, v)
	endtask : w
	task automatic pls(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
	endtask : pls
	task automatic t_on;
		i_mpks_host.press(0, 10);
		cyc(12);
		`CHK(O_POWER_EN, 1'h0)
		i_mpks_host.press(0, 22);
		w(3'h1);
		w(3'h5);
		`CHK(O_CORE_RESET_N, 1'h1)
		i_mpks_host.press(1, 10);
		w(3'h1);
		w(3'h5);
	endtask : t_on
	task automatic t_off;
		i_mpks_host.press(0, 22);
		w(3'h7);
		pls(I_DETACH_DONE);
		w(3'h1);
		w(3'h0);
		i_mpks_host.press(1, 10);
		cyc(12);
		`CHK(O_POWER_EN, 1'h0)
	endtask : t_off
	task automatic t_chg;
		I_CHARGER_PRESENT = 1;
		cyc(10);
		`CHK(O_POWER_EN, 1'h0)
		I_CE = 0;
		I_BATTERY_PRESENT = 1;
		cyc(10);
		`CHK(O_POWER_EN, 1'h0)
		I_CE = 1;
		w(3'h5);
		I_CHARGER_PRESENT = 0;
		pls(I_SW_SHUTDOWN);
		w(3'h7);
		w(3'h0);
	endtask : t_chg
	task automatic end_of_test;
		if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	initial begin
		cyc(20);
		I_RST_N = 1;
		cyc(2);
		t_on();
		t_off();
		t_chg();
		end_of_test();
	end
	initial begin
		cyc(3000);
		fail_count++;
		end_of_test();
	end
endmodule : tb
bind mpks_top mpks_monitor i_mpks_monitor (.*);
